// ===== tmc_params.svh
// constants for the sixteen-bit timer with input capture
// What this block does
// - high location reads and writes the staging byte
// - low-byte write loads all sixteen bits together
// - counter clears, increments or decrements per tick
// - clock select zero stops counting, access remains
// - host counter write beats any count action
// - four-bit waveform mode field picks sequence
// - overflow flag set per mode, raises interrupt
// - matching edge copies counter into capture register
// - capture flag set with the copy
// - enabled flag interrupts; ack or write-one clears
// - capture low read stages its high byte
// - capture register writable only as count limit
// - comparator select switches the capture trigger
// - inputs synchronised; filter adds four cycles
// - capture input off in capture-limit modes
// - filter output changes after four agreeing samples
// - filter enabled by bit, runs on system clock
// - new capture always overwrites the register
// - own drive of capture pin triggers captures
// - limit is fixed, compare A or capture register
`ifndef TMC_PARAMS_SVH
`define TMC_PARAMS_SVH

// ----------------------------------------
// host byte locations
// ----------------------------------------
`define TMC_LOC_CNT_LOW  2'h0
`define TMC_LOC_CNT_HIGH 2'h1
`define TMC_LOC_CAP_LOW  2'h2
`define TMC_LOC_CAP_HIGH 2'h3

// ----------------------------------------
// count limits and reset values
// ----------------------------------------
`define TMC_TOP_8BIT  16'h00FF
`define TMC_TOP_9BIT  16'h01FF
`define TMC_TOP_10BIT 16'h03FF
`define TMC_MAX       16'hFFFF
`define TMC_BOTTOM    16'h0000
`define TMC_ONE       16'h0001
`define TMC_BYTE_RST  8'h00

// ----------------------------------------
// clock select codes and prescaler taps
// ----------------------------------------
`define TMC_CS_STOP    3'h0
`define TMC_CS_DIV1    3'h1
`define TMC_CS_DIV8    3'h2
`define TMC_CS_DIV64   3'h3
`define TMC_CS_DIV256  3'h4
`define TMC_CS_DIV1024 3'h5
`define TMC_CS_EXT_FALL 3'h6
`define TMC_CS_EXT_RISE 3'h7
`define TMC_PRE_MASK8    10'h007
`define TMC_PRE_MASK64   10'h03F
`define TMC_PRE_MASK256  10'h0FF
`define TMC_PRE_MASK1024 10'h3FF

// ----------------------------------------
// noise filter
// ----------------------------------------
`define TMC_FILT_ALL_ONE  4'hF
`define TMC_FILT_ALL_ZERO 4'h0

`endif

// ===== tmc_pkg.sv
// types shared by the timer files
package tmc_pkg;

  // ----------------------------------------
  // count direction, one-hot
  // ----------------------------------------
  typedef enum logic [1:0]
  {
    TMC_DIR_UP   = 2'b01,
    TMC_DIR_DOWN = 2'b10
  } tmc_dir_t;

endpackage : tmc_pkg

// ===== tmc_edge_unit.sv
// optional four-sample filter and edge detector
`timescale 1ns/1ns
module tmc_edge_unit
  import tmc_pkg::*;
(
  input  wire logic clk,
  input  wire logic reset_n,
  input  wire logic sample_in,
  input  wire logic filter_enable,
  input  wire logic rising_sel,
  input  wire logic gate_enable,
  output logic      edge_pulse
);

  `include "tmc_params.svh"

  logic [3:0] shift_reg;
  logic [3:0] shift_next;
  logic       filt_reg;
  logic       filt_next;
  logic       prev_reg;
  logic       prev_next;
  logic       pulse_reg;
  logic       pulse_next;
  logic       level;

  // ----------------------------------------
  // filter and detector
  // ----------------------------------------
  always_comb
  begin
    shift_next = {shift_reg[2:0], sample_in};
    filt_next  = filt_reg;
    // judge the window that includes this sample, so the filter adds exactly four cycles
    if (shift_next == `TMC_FILT_ALL_ONE)
    begin
      filt_next = 1'b1;
    end
    else if (shift_next == `TMC_FILT_ALL_ZERO)
    begin
      filt_next = 1'b0;
    end
    // only the filtered level feeds the detector when filtering
    level      = filter_enable ? filt_reg : sample_in;
    prev_next  = level;
    pulse_next = gate_enable && (level != prev_reg) && (level == rising_sel);
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      shift_reg <= `TMC_FILT_ALL_ZERO;
      filt_reg  <= 1'b0;
      prev_reg  <= 1'b0;
      pulse_reg <= 1'b0;
    end
    else
    begin
      shift_reg <= shift_next;
      filt_reg  <= filt_next;
      prev_reg  <= prev_next;
      pulse_reg <= pulse_next;
    end
  end

  assign edge_pulse = pulse_reg;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  a_filter_agree: assert property (@(posedge clk) disable iff (!reset_n)
    (filt_reg != $past(filt_reg)) |->
      (shift_reg == `TMC_FILT_ALL_ONE || shift_reg == `TMC_FILT_ALL_ZERO))
    else $error("filter output changed without four agreeing samples");

endmodule : tmc_edge_unit

// ===== tmc_timer.sv
// sixteen-bit timer counter with staging byte and input capture
`timescale 1ns/1ns
module tmc_timer
  import tmc_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        reset_n,
  input  wire logic [1:0]  host_addr,
  input  wire logic        host_wr,
  input  wire logic        host_rd,
  input  wire logic [7:0]  host_wdata,
  output logic      [7:0]  host_rdata,
  input  wire logic [1:0]  wgm_low_a,
  input  wire logic [1:0]  wgm_high_b,
  input  wire logic [2:0]  clock_source_select,
  input  wire logic        noise_filter_enable,
  input  wire logic        capture_rising_edge,
  input  wire logic        comparator_capture_select,
  input  wire logic        capture_irq_enable,
  input  wire logic        overflow_irq_enable,
  input  wire logic [15:0] compare_register_a,
  input  wire logic        capture_pin,
  input  wire logic        comparator_output,
  input  wire logic        external_count_pin,
  input  wire logic        capture_flag_clear,
  input  wire logic        overflow_flag_clear,
  input  wire logic        capture_irq_ack,
  input  wire logic        overflow_irq_ack,
  output logic      [15:0] count_value,
  output logic      [15:0] capture_register,
  output logic             capture_flag,
  output logic             overflow_flag,
  output logic             capture_irq,
  output logic             overflow_irq
);

  `include "tmc_params.svh"

  // ----------------------------------------
  // mode decoding
  // ----------------------------------------
  function automatic logic icr_top(input logic [3:0] m);
    icr_top = (m == 4'h8) || (m == 4'hA) || (m == 4'hC) || (m == 4'hE);
  endfunction : icr_top

  function automatic logic up_down(input logic [3:0] m);
    up_down = (m >= 4'h1 && m <= 4'h3) || (m >= 4'h8 && m <= 4'hB);
  endfunction : up_down

  function automatic logic fast_pwm(input logic [3:0] m);
    fast_pwm = (m >= 4'h5 && m <= 4'h7) || (m == 4'hE) || (m == 4'hF);
  endfunction : fast_pwm

  function automatic logic [15:0] top_of(input logic [3:0] m, input logic [15:0] ocra,
                                         input logic [15:0] icr);
    top_of = `TMC_MAX;
    unique case (m)
      4'h1, 4'h5:               top_of = `TMC_TOP_8BIT;
      4'h2, 4'h6:               top_of = `TMC_TOP_9BIT;
      4'h3, 4'h7:               top_of = `TMC_TOP_10BIT;
      4'h4, 4'h9, 4'hB, 4'hF:   top_of = ocra;
      4'h8, 4'hA, 4'hC, 4'hE:   top_of = icr;
      4'h0, 4'hD:               top_of = `TMC_MAX;
    endcase
  endfunction : top_of

  logic [3:0] mode;
  assign mode = {wgm_high_b, wgm_low_a};

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  logic [2:0] sync1_reg;
  logic [2:0] sync2_reg;

  // own drive of the capture pin comes back through the pad input
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      sync1_reg <= 3'h0;
      sync2_reg <= 3'h0;
    end
    else
    begin
      sync1_reg <= {external_count_pin, comparator_output, capture_pin};
      sync2_reg <= sync1_reg;
    end
  end

  // ----------------------------------------
  // edge units
  // ----------------------------------------
  logic cap_level;
  logic cap_event;
  logic ext_event;
  logic cap_gate;

  // switching source may itself look like an edge; software clears the flag
  assign cap_level = comparator_capture_select ? sync2_reg[1] : sync2_reg[0];
  assign cap_gate  = !icr_top(mode);

  tmc_edge_unit u_cap_edge
  (
    .clk           (clk),
    .reset_n       (reset_n),
    .sample_in     (cap_level),
    .filter_enable (noise_filter_enable),
    .rising_sel    (capture_rising_edge),
    .gate_enable   (cap_gate),
    .edge_pulse    (cap_event)
  );

  tmc_edge_unit u_ext_edge
  (
    .clk           (clk),
    .reset_n       (reset_n),
    .sample_in     (sync2_reg[2]),
    .filter_enable (1'b0),
    .rising_sel    (clock_source_select[0]),
    .gate_enable   (1'b1),
    .edge_pulse    (ext_event)
  );

  // ----------------------------------------
  // tick selection
  // ----------------------------------------
  logic [9:0] pre_reg;
  logic [9:0] pre_next;
  logic       tick;

  always_comb
  begin
    pre_next = pre_reg + 10'h001;
    tick     = 1'b0;
    unique case (clock_source_select)
      `TMC_CS_STOP:     tick = 1'b0;
      `TMC_CS_DIV1:     tick = 1'b1;
      `TMC_CS_DIV8:     tick = (pre_reg & `TMC_PRE_MASK8) == `TMC_PRE_MASK8;
      `TMC_CS_DIV64:    tick = (pre_reg & `TMC_PRE_MASK64) == `TMC_PRE_MASK64;
      `TMC_CS_DIV256:   tick = (pre_reg & `TMC_PRE_MASK256) == `TMC_PRE_MASK256;
      `TMC_CS_DIV1024:  tick = pre_reg == `TMC_PRE_MASK1024;
      `TMC_CS_EXT_FALL,
      `TMC_CS_EXT_RISE: tick = ext_event;
    endcase
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      pre_reg <= 10'h000;
    end
    else
    begin
      pre_reg <= pre_next;
    end
  end

  // ----------------------------------------
  // counter, staging byte, capture, host read
  // ----------------------------------------
  logic [15:0] cnt_reg;
  logic [15:0] cnt_next;
  logic [15:0] cap_reg;
  logic [15:0] cap_next;
  logic [7:0]  temp_reg;
  logic [7:0]  temp_next;
  logic [7:0]  rdata_reg;
  logic [7:0]  rdata_next;
  tmc_dir_t    dir_reg;
  tmc_dir_t    dir_next;
  logic        tov_set;
  logic [15:0] top;
  logic        cnt_wr;

  assign top    = top_of(mode, compare_register_a, cap_reg);
  assign cnt_wr = host_wr && (host_addr == `TMC_LOC_CNT_LOW);

  always_comb
  begin
    cnt_next   = cnt_reg;
    dir_next   = dir_reg;
    tov_set    = 1'b0;
    cap_next   = cap_reg;
    temp_next  = temp_reg;
    rdata_next = rdata_reg;
    if (cnt_wr)
    begin
      cnt_next = {temp_reg, host_wdata};
    end
    else if (tick)
    begin
      if (up_down(mode))
      begin
        unique case (dir_reg)
          TMC_DIR_UP:
          begin
            if (cnt_reg >= top)
            begin
              dir_next = TMC_DIR_DOWN;
              cnt_next = cnt_reg - `TMC_ONE;
            end
            else
            begin
              cnt_next = cnt_reg + `TMC_ONE;
            end
          end
          TMC_DIR_DOWN:
          begin
            if (cnt_reg == `TMC_BOTTOM)
            begin
              dir_next = TMC_DIR_UP;
              cnt_next = cnt_reg + `TMC_ONE;
              tov_set  = 1'b1;
            end
            else
            begin
              cnt_next = cnt_reg - `TMC_ONE;
            end
          end
        endcase
      end
      else
      begin
        dir_next = TMC_DIR_UP;
        if (cnt_reg == top)
        begin
          cnt_next = `TMC_BOTTOM;
        end
        else
        begin
          cnt_next = cnt_reg + `TMC_ONE;
        end
        tov_set = fast_pwm(mode) ? (cnt_reg == top) : (cnt_reg == `TMC_MAX);
      end
    end
    // host writes to the staging byte through either high location
    if (host_wr && (host_addr == `TMC_LOC_CNT_HIGH || host_addr == `TMC_LOC_CAP_HIGH))
    begin
      temp_next = host_wdata;
    end
    if (host_wr && host_addr == `TMC_LOC_CAP_LOW && icr_top(mode))
    begin
      cap_next = {temp_reg, host_wdata};
    end
    if (cap_event)
    begin
      cap_next = cnt_reg;
    end
    if (host_rd)
    begin
      unique case (host_addr)
        `TMC_LOC_CNT_LOW:
        begin
          rdata_next = cnt_reg[7:0];
          temp_next  = cnt_reg[15:8];
        end
        `TMC_LOC_CAP_LOW:
        begin
          rdata_next = cap_reg[7:0];
          temp_next  = cap_reg[15:8];
        end
        `TMC_LOC_CNT_HIGH,
        `TMC_LOC_CAP_HIGH:
        begin
          rdata_next = temp_reg;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      cnt_reg   <= `TMC_BOTTOM;
      cap_reg   <= `TMC_BOTTOM;
      temp_reg  <= `TMC_BYTE_RST;
      rdata_reg <= `TMC_BYTE_RST;
      dir_reg   <= TMC_DIR_UP;
    end
    else
    begin
      cnt_reg   <= cnt_next;
      cap_reg   <= cap_next;
      temp_reg  <= temp_next;
      rdata_reg <= rdata_next;
      dir_reg   <= dir_next;
    end
  end

  // ----------------------------------------
  // flags and interrupt requests
  // ----------------------------------------
  logic cap_flag_reg;
  logic cap_flag_next;
  logic tov_flag_reg;
  logic tov_flag_next;
  logic cap_irq_reg;
  logic cap_irq_next;
  logic tov_irq_reg;
  logic tov_irq_next;

  // a set in the cycle of a clear wins so no event is lost
  always_comb
  begin
    cap_flag_next = cap_event || (cap_flag_reg && !(capture_flag_clear || capture_irq_ack));
    tov_flag_next = tov_set || (tov_flag_reg && !(overflow_flag_clear || overflow_irq_ack));
    cap_irq_next  = cap_flag_next && capture_irq_enable;
    tov_irq_next  = tov_flag_next && overflow_irq_enable;
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      cap_flag_reg <= 1'b0;
      tov_flag_reg <= 1'b0;
      cap_irq_reg  <= 1'b0;
      tov_irq_reg  <= 1'b0;
    end
    else
    begin
      cap_flag_reg <= cap_flag_next;
      tov_flag_reg <= tov_flag_next;
      cap_irq_reg  <= cap_irq_next;
      tov_irq_reg  <= tov_irq_next;
    end
  end

  assign host_rdata       = rdata_reg;
  assign count_value      = cnt_reg;
  assign capture_register = cap_reg;
  assign capture_flag     = cap_flag_reg;
  assign overflow_flag    = tov_flag_reg;
  assign capture_irq      = cap_irq_reg;
  assign overflow_irq     = tov_irq_reg;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);

  a_cnt_write_wins: assert property (cnt_wr |=>
    count_value == {$past(temp_reg), $past(host_wdata)})
    else $error("counter low write did not load the full value");

  a_stop_holds: assert property ((clock_source_select == `TMC_CS_STOP) && !cnt_wr |=>
    $stable(count_value))
    else $error("counter moved with no clock source");

  a_temp_on_read: assert property (host_rd && host_addr == `TMC_LOC_CAP_LOW && !host_wr |=>
    temp_reg == $past(cap_reg[15:8]))
    else $error("capture low read did not stage the high byte");

  a_capture_copy: assert property (cap_event |=>
    capture_register == $past(cnt_reg) && capture_flag)
    else $error("capture did not copy counter and set flag together");

  a_set_beats_clr: assert property (cap_event && capture_flag_clear |=> capture_flag)
    else $error("capture event lost to a flag clear");

  a_capture_gated: assert property (icr_top(mode) && $past(icr_top(mode)) |-> !cap_event)
    else $error("capture fired in a capture-limit mode");

  a_cap_write_mode: assert property (host_wr && host_addr == `TMC_LOC_CAP_LOW &&
    !icr_top(mode) && !cap_event |=> $stable(capture_register))
    else $error("capture register written outside capture-limit modes");

  a_fast_overflow: assert property (tick && !cnt_wr && fast_pwm(mode) && cnt_reg == top |=>
    overflow_flag && count_value == `TMC_BOTTOM)
    else $error("fast mode did not wrap and flag at the limit");

  a_irq_follows: assert property (capture_irq |-> capture_flag && $past(capture_irq_enable))
    else $error("capture request without flag and enable");

endmodule : tmc_timer

// ===== tmc_host_model.sv
// processor-side byte bus model for the timer host port
`timescale 1ns/1ns
module tmc_host_model
(
  input  wire logic       clk,
  input  wire logic [7:0] host_rdata,
  output logic      [1:0] host_addr,
  output logic            host_wr,
  output logic            host_rd,
  output logic      [7:0] host_wdata
);
  // ----------------------------------------
  // byte cycles
  // ----------------------------------------
  initial
  begin
    host_addr  = 2'h0;
    host_wr    = 1'b0;
    host_rd    = 1'b0;
    host_wdata = 8'h00;
  end
  // strobe lasts one edge; released data shows the inverse so stale bytes never pass
  task automatic wr_byte(input logic [1:0] a, input logic [7:0] d);
    @(negedge clk);
    host_addr  = a;
    host_wdata = d;
    host_wr    = 1'b1;
    @(negedge clk);
    host_wr    = 1'b0;
    host_wdata = ~d;
  endtask : wr_byte
  // data is taken one edge after the taking edge, where it is settled either way
  task automatic rd_byte(input logic [1:0] a, output logic [7:0] d);
    @(negedge clk);
    host_addr = a;
    host_rd   = 1'b1;
    @(negedge clk);
    host_rd   = 1'b0;
    @(negedge clk);
    d = host_rdata;
  endtask : rd_byte
  // ----------------------------------------
  // word cycles
  // ----------------------------------------
  // no interrupt code runs here, so a word access is never split
  task automatic wr16(input logic [1:0] lo, input logic [15:0] v);
    wr_byte(lo | 2'h1, v[15:8]);
    wr_byte(lo, v[7:0]);
  endtask : wr16
  task automatic rd16(input logic [1:0] lo, output logic [15:0] v);
    rd_byte(lo, v[7:0]);
    rd_byte(lo | 2'h1, v[15:8]);
  endtask : rd16
endmodule : tmc_host_model

// ===== tb.sv
// self-checking bench for the sixteen-bit timer with input capture
`timescale 1ns/1ns
module tb;
  import tmc_pkg::*;
  logic        clk, reset_n, host_wr, host_rd, noise_filter_enable, capture_rising_edge;
  logic        comparator_capture_select, capture_irq_enable, overflow_irq_enable, capture_pin;
  logic        comparator_output, external_count_pin, capture_flag_clear, overflow_flag_clear;
  logic        capture_irq_ack, overflow_irq_ack, capture_flag, overflow_flag, capture_irq, overflow_irq;
  logic [1:0]  host_addr, wgm_low_a, wgm_high_b;
  logic [2:0]  clock_source_select;
  logic [7:0]  host_wdata, host_rdata, rb;
  logic [15:0] compare_register_a, count_value, capture_register, seed, v, a, rw;
  logic [3:0]  modes[5] = '{4'h0, 4'h5, 4'h6, 4'h7, 4'hf};
  int          div_tab[4] = '{8, 64, 256, 1024};
  int          err_total, check_count, lat0, lat1, n;

  tmc_timer i_dut (.clk, .reset_n, .host_addr, .host_wr, .host_rd, .host_wdata, .host_rdata, .wgm_low_a,
    .wgm_high_b, .clock_source_select, .noise_filter_enable, .capture_rising_edge, .comparator_capture_select,
    .capture_irq_enable, .overflow_irq_enable, .compare_register_a, .capture_pin, .comparator_output,
    .external_count_pin, .capture_flag_clear, .overflow_flag_clear, .capture_irq_ack, .overflow_irq_ack,
    .count_value, .capture_register, .capture_flag, .overflow_flag, .capture_irq, .overflow_irq);
  tmc_host_model i_host (.clk, .host_rdata, .host_addr, .host_wr, .host_rd, .host_wdata);

  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // ----------------------------------------
  // expectations and helpers
  // ----------------------------------------
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr
  function automatic logic [15:0] top_of(input logic [3:0] m, input logic [15:0] ocra);
    case (m)
      4'h5: return 16'h00ff;
      4'h6: return 16'h01ff;
      4'h7: return 16'h03ff;
      4'hf: return ocra;
      default: return 16'hffff;
    endcase
  endfunction : top_of
  task automatic cyc(input int k);
    repeat (k) @(negedge clk);
  endtask : cyc
  task automatic pulse(ref logic s);
    s = 1'b1;
    cyc(1);
    s = 1'b0;
    cyc(1);
  endtask : pulse
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    check_count++;
    if (got !== exp)
    begin
      err_total++;
      $display("[ERR] t=%0t %s: got %h expected %h", $time, what, got, exp);
    end
  endtask : chk
  task automatic chk_b(input logic got, input logic exp, input string what);
    chk({15'h0000, got}, {15'h0000, exp}, what);
  endtask : chk_b
  task automatic results;
    $display("checks %0d, errors %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : results
  // bounded wait on the overflow flag (ovf=1) or the capture flag
  task automatic wait_flag(input logic ovf, input int bound, output int k);
    k = 0;
    while ((ovf ? overflow_flag : capture_flag) !== 1'b1)
    begin
      if (k == bound)
      begin
        err_total++;
        $display("[ERR] t=%0t flag never rose", $time);
        results;
      end
      cyc(1);
      k++;
    end
  endtask : wait_flag
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial
  begin
    {wgm_low_a, wgm_high_b, clock_source_select, noise_filter_enable, capture_rising_edge,
      comparator_capture_select, capture_irq_enable, overflow_irq_enable, compare_register_a, capture_pin,
      comparator_output, external_count_pin, capture_flag_clear, overflow_flag_clear, capture_irq_ack,
      overflow_irq_ack} = '0;
    reset_n = 1'b0;
    err_total = 0;
    check_count = 0;
    seed = 16'h0011;
    cyc(12);
    reset_n = 1'b1;
    cyc(1);
    chk(count_value | capture_register, 16'h0000, "reset values");
    chk_b(capture_flag | overflow_flag, 1'b0, "reset flags");
    for (int i = 0; i < 6; i++)
    begin
      seed = lfsr(seed);
      i_host.wr16(2'h0, seed);
      cyc(4);
      chk(count_value, seed, "held word");
      i_host.rd16(2'h0, rw);
      chk(rw, seed, "word read");
    end
    // high read must come from the byte staged by the low read, not the live counter
    i_host.wr16(2'h0, 16'h00f0);
    clock_source_select = 3'h1;
    i_host.rd_byte(2'h0, rb);
    cyc(40);
    i_host.rd_byte(2'h1, rb);
    chk({8'h00, rb}, 16'h0000, "staged high");
    chk({8'h00, count_value[15:8]}, 16'h0001, "live high");
    seed = lfsr(seed);
    i_host.wr16(2'h0, seed);
    chk(count_value, seed, "write over tick");
    a = count_value;
    cyc(50);
    chk(count_value - a, 16'h0032, "up count");
    for (int k = 0; k < 4; k++)
    begin
      clock_source_select = 3'(k + 2);
      cyc(2);
      a = count_value;
      cyc(2 * div_tab[k]);
      chk(count_value - a, 16'h0002, "prescaled ticks");
    end
    for (int k = 6; k < 8; k++)
    begin
      clock_source_select = 3'(k);
      cyc(2);
      a = count_value;
      repeat (10)
      begin
        external_count_pin = 1'b1;
        cyc(3);
        external_count_pin = 1'b0;
        cyc(3);
      end
      cyc(6);
      chk(count_value - a, 16'h000a, "pin ticks");
    end
    clock_source_select = 3'h0;
    a = count_value;
    cyc(30);
    chk(count_value, a, "stopped");
    overflow_irq_enable = 1'b1;
    for (int k = 0; k < 5; k++)
    begin
      seed = lfsr(seed);
      compare_register_a = 16'h0400 + {6'h00, seed[9:0]};
      {wgm_high_b, wgm_low_a} = modes[k];
      v = top_of(modes[k], compare_register_a);
      i_host.wr16(2'h0, v - 16'h0003);
      pulse(overflow_flag_clear);
      chk_b(overflow_flag, 1'b0, "flag cleared");
      clock_source_select = 3'h1;
      wait_flag(1'b1, 12, n);
      chk_b(count_value < 16'h0004, 1'b1, "wrap at limit");
      chk_b(overflow_irq, 1'b1, "overflow irq");
      clock_source_select = 3'h0;
    end
    pulse(overflow_irq_ack);
    chk_b(overflow_flag, 1'b0, "service clear");
    {wgm_high_b, wgm_low_a} = 4'h1;
    i_host.wr16(2'h0, 16'h00fc);
    clock_source_select = 3'h1;
    cyc(10);
    clock_source_select = 3'h0;
    chk_b(count_value < 16'h00fc && count_value > 16'h00f0, 1'b1, "turned down");
    // ----------------------------------------
    // input capture
    // ----------------------------------------
    {wgm_high_b, wgm_low_a} = 4'h0;
    capture_irq_enable = 1'b1;
    capture_rising_edge = 1'b1;
    seed = lfsr(seed);
    i_host.wr16(2'h0, seed);
    capture_pin = 1'b1;  // bench drives the pin as software would
    wait_flag(1'b0, 30, lat0);
    chk(capture_register, seed, "captured count");
    chk_b(capture_irq, 1'b1, "capture irq");
    pulse(capture_flag_clear);
    chk_b(capture_flag, 1'b0, "write-one clear");
    capture_pin = 1'b0;
    cyc(15);
    chk_b(capture_flag, 1'b0, "wrong edge");
    seed = lfsr(seed);
    i_host.wr16(2'h0, seed);
    capture_pin = 1'b1;
    cyc(3);
    pulse(capture_flag_clear);  // clear meets the capture pulse
    chk_b(capture_flag, 1'b1, "set beats clear");
    wait_flag(1'b0, 30, n);
    chk(capture_register, seed, "second capture");
    capture_rising_edge = 1'b0;
    v = ~seed;
    i_host.wr16(2'h0, v);
    capture_pin = 1'b0;
    cyc(lat0 + 2);
    chk(capture_register, v, "overwrite unread");
    i_host.rd16(2'h2, rw);
    chk(rw, v, "capture read");
    pulse(capture_irq_ack);
    chk_b(capture_flag, 1'b0, "service clear");
    capture_rising_edge = 1'b1;
    capture_irq_enable = 1'b0;
    comparator_capture_select = 1'b1;
    cyc(6);
    pulse(capture_flag_clear);
    capture_pin = 1'b1;
    cyc(15);
    chk_b(capture_flag, 1'b0, "pin ignored");
    seed = lfsr(seed);
    i_host.wr16(2'h0, seed);
    comparator_output = 1'b1;
    wait_flag(1'b0, 30, n);
    chk(capture_register, seed, "comparator capture");
    chk_b(capture_irq, 1'b0, "irq masked");
    comparator_capture_select = 1'b0;
    comparator_output = 1'b0;
    capture_pin = 1'b0;
    noise_filter_enable = 1'b1;
    cyc(12);
    pulse(capture_flag_clear);
    capture_pin = 1'b1;
    cyc(3);
    capture_pin = 1'b0;
    cyc(20);
    chk_b(capture_flag, 1'b0, "short pulse rejected");
    capture_pin = 1'b1;
    wait_flag(1'b0, 40, lat1);
    chk(16'(lat1), 16'(lat0 + 4), "filter delay");
    capture_pin = 1'b0;
    cyc(12);
    pulse(capture_flag_clear);
    {wgm_high_b, wgm_low_a} = 4'hc;
    capture_pin = 1'b1;
    cyc(20);
    chk_b(capture_flag, 1'b0, "gated in limit mode");
    seed = lfsr(seed);
    i_host.wr16(2'h2, seed);
    chk(capture_register, seed, "limit write");
    i_host.wr_byte(2'h1, 8'h5a);
    i_host.wr_byte(2'h0, seed[7:0]);
    i_host.wr_byte(2'h2, ~seed[7:0]);
    chk(count_value, {8'h5a, seed[7:0]}, "shared high count");
    chk(capture_register, {8'h5a, ~seed[7:0]}, "shared high capture");
    capture_pin = 1'b0;
    cyc(12);
    {wgm_high_b, wgm_low_a} = 4'h0;
    i_host.wr16(2'h2, 16'h1234);
    chk(capture_register, {8'h5a, ~seed[7:0]}, "write refused");
    results;
  end
endmodule : tb
